// ### hdl/bsum_alarm.sv
`timescale 1ns/1ps
module bsum_alarm (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic fault_i,
    input wire logic lockable_i,
    input wire logic lock_i,
    input wire logic self_ack_i,
    input wire logic ack_i,
    output logic alarm_o
);
    logic alarm_q;
    logic alarm_d;
    logic eval_w;
    logic fault_w;

    always_comb begin
        eval_w = !lockable_i || !lock_i;
        fault_w = eval_w && fault_i;
        alarm_d = alarm_q;
        if (alarm_q && !fault_w && self_ack_i) begin
            alarm_d = 1'b0;
        end
        if (alarm_q && !fault_w && ack_i) begin
            alarm_d = 1'b0;
        end
        if (fault_w) begin
            alarm_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            alarm_q <= 1'b0;
        end else begin
            alarm_q <= alarm_d;
        end
    end

    assign alarm_o = alarm_q;

    a_self_ack_clear: assert property (@(posedge clk_i) disable iff (reset_i)
        alarm_q && self_ack_i && !fault_i |=> !alarm_q)
        else $error("self acknowledged alarm did not clear");
    a_latched_hold: assert property (@(posedge clk_i) disable iff (reset_i)
        alarm_q && !self_ack_i && !ack_i |=> alarm_q)
        else $error("latched alarm dropped without acknowledge");
    a_lock_blocks: assert property (@(posedge clk_i) disable iff (reset_i)
        !alarm_q && lockable_i && lock_i |=> !alarm_q)
        else $error("locked alarm was raised");
    a_nolock_eval: assert property (@(posedge clk_i) disable iff (reset_i)
        fault_i && !lockable_i |=> alarm_q)
        else $error("unlockable alarm missed its fault");
endmodule

// ### hdl/bsum_monitor.sv
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
module bsum_monitor #(
    parameter int unsigned TICK_CYCLES = bsum_pkg::SEC_CYCLES
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic sync_active_i,
    input wire logic side_b_breaker_closed_i,
    input wire logic side_b_breaker_open_i,
    input wire logic unload_active_i,
    input wire logic [15:0] side_b_power_i,
    input wire logic monitor_lock_i,
    input wire logic panel_ack_i,
    input wire logic ext_ack_i,
    output logic side_b_breaker_open_cmd_o,
    output logic sync_timeout_flag_o,
    output logic sync_timeout_message_o,
    output bsum_pkg::bsum_class_e sync_class_o,
    output logic unload_mismatch_alarm_o,
    output bsum_pkg::bsum_class_e unload_class_o,
    output logic irq_o
);
    import bsum_pkg::*;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    logic [31:0] prdata_q, prdata_d;
    logic pslverr_q, pslverr_d;
    logic [15:0] ctrl_q, ctrl_d;
    logic [9:0] sync_dly_q, sync_dly_d;
    logic [9:0] unl_dly_q, unl_dly_d;
    logic [9:0] trip_q, trip_d;
    logic [15:0] rated_q, rated_d;
    logic [2:0] irq_stat_q, irq_stat_d;
    logic [2:0] irq_mask_q, irq_mask_d;
    logic [31:0] pre_q, pre_d;
    logic [9:0] sync_cnt_q, sync_cnt_d;
    logic [9:0] unl_cnt_q, unl_cnt_d;
    logic open_q, open_d;
    logic [1:0] alarm_prev_q, alarm_prev_d;
    logic open_prev_q, open_prev_d;
    logic setup_w, wr_w, ack_wr_w, ack_w, tick_w;
    logic sync_run_w, sync_fault_w, below_w, unl_exp_w;
    logic [26:0] pwr_scaled_w, trip_abs_w;
    logic [2:0] irq_evt_w;
    logic [1:0] fault_w, lockable_w, self_ack_w, alarm_w;
    logic [31:0] status_w;

    function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lo,
                                           input logic [9:0] hi);
        logic [9:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // out-of-range class codes fall back to the default class
    function automatic logic [2:0] legal_cls(input logic [2:0] v);
        logic [2:0] r;
        r = v;
        if (v > 3'(BSUM_CLS_CTRL)) begin
            r = 3'(CLS_RST);
        end
        return r;
    endfunction

    // zero wait state slave, read data registered in the setup cycle
    assign setup_w = psel_i && !penable_i;
    assign wr_w = psel_i && penable_i && pwrite_i;
    assign ack_wr_w = wr_w && (paddr_i == OFS_ACK) && pwdata_i[0];
    assign ack_w = panel_ack_i || ext_ack_i || ack_wr_w;
    assign pready_o = 1'b1;
    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q;

    // trip level in 0.1 % of rated power: compare power*1000 < level*rated
    assign pwr_scaled_w = 27'(side_b_power_i) * TRIP_SCALE;
    assign trip_abs_w = 27'(trip_q) * 27'(rated_q);
    assign below_w = pwr_scaled_w < trip_abs_w;

    assign status_w = {27'h0, unload_active_i, sync_run_w, open_q, alarm_w[1], alarm_w[0]};
    assign irq_evt_w = {open_q && !open_prev_q,
                        alarm_w[1] && !alarm_prev_q[1],
                        alarm_w[0] && !alarm_prev_q[0]};

    always_comb begin
        ctrl_d = ctrl_q;
        sync_dly_d = sync_dly_q;
        unl_dly_d = unl_dly_q;
        trip_d = trip_q;
        rated_d = rated_q;
        irq_mask_d = irq_mask_q;
        irq_stat_d = irq_stat_q;
        prdata_d = prdata_q;
        pslverr_d = pslverr_q;
        if (setup_w) begin
            prdata_d = 32'h0;
            pslverr_d = 1'b0;
            unique case (paddr_i)
                OFS_CTRL: prdata_d = {16'h0, ctrl_q};
                OFS_SYNC_DLY: prdata_d = {22'h0, sync_dly_q};
                OFS_UNL_DLY: prdata_d = {22'h0, unl_dly_q};
                OFS_TRIP: prdata_d = {22'h0, trip_q};
                OFS_RATED: prdata_d = {16'h0, rated_q};
                OFS_STATUS: prdata_d = status_w;
                OFS_IRQ_STAT: prdata_d = {29'h0, irq_stat_q};
                OFS_IRQ_MASK: prdata_d = {29'h0, irq_mask_q};
                OFS_ACK: prdata_d = 32'h0;
                default: pslverr_d = 1'b1;
            endcase
        end
        if (wr_w) begin
            unique case (paddr_i)
                OFS_CTRL: begin
                    ctrl_d = pwdata_i[15:0] & 16'h7377;
                    ctrl_d[CTRL_SYNC_CLS +: 3] = legal_cls(pwdata_i[CTRL_SYNC_CLS +: 3]);
                    ctrl_d[CTRL_UNL_CLS +: 3] = legal_cls(pwdata_i[CTRL_UNL_CLS +: 3]);
                end
                OFS_SYNC_DLY: sync_dly_d = clamp10(pwdata_i[9:0], SYNC_DLY_MIN, SYNC_DLY_MAX);
                OFS_UNL_DLY: unl_dly_d = clamp10(pwdata_i[9:0], UNL_DLY_MIN, UNL_DLY_MAX);
                OFS_TRIP: trip_d = clamp10(pwdata_i[9:0], TRIP_MIN, TRIP_MAX);
                OFS_RATED: rated_d = pwdata_i[15:0];
                OFS_IRQ_STAT: irq_stat_d = irq_stat_q & ~pwdata_i[2:0];
                OFS_IRQ_MASK: irq_mask_d = pwdata_i[2:0];
                default: begin
                end
            endcase
        end
        // a new event wins over a simultaneous clear
        irq_stat_d = irq_stat_d | irq_evt_w;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_q <= 16'h0001 | (16'(CLS_RST) << CTRL_SYNC_CLS)
                      | (16'(CLS_RST) << CTRL_UNL_CLS);
            sync_dly_q <= SYNC_DLY_RST;
            unl_dly_q <= UNL_DLY_RST;
            trip_q <= TRIP_RST;
            rated_q <= RATED_RST;
            irq_stat_q <= 3'h0;
            irq_mask_q <= 3'h0;
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            sync_dly_q <= sync_dly_d;
            unl_dly_q <= unl_dly_d;
            trip_q <= trip_d;
            rated_q <= rated_d;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // free-running seconds prescaler: delays resolve to within one second
    assign tick_w = (pre_q == TICK_CYCLES - 1);
    assign sync_run_w = sync_active_i && !side_b_breaker_closed_i;
    assign sync_fault_w = ctrl_q[CTRL_SYNC_EN] && sync_run_w && (sync_cnt_q >= sync_dly_q);
    assign unl_exp_w = unload_active_i && !side_b_breaker_open_i && (unl_cnt_q >= unl_dly_q);

    always_comb begin
        pre_d = tick_w ? 32'h0 : pre_q + 32'h1;
        sync_cnt_d = sync_cnt_q;
        if (!sync_run_w) begin
            sync_cnt_d = 10'h0;
        end else if (tick_w && sync_cnt_q != SEC_MAX) begin
            sync_cnt_d = sync_cnt_q + 10'h1;
        end
        unl_cnt_d = unl_cnt_q;
        if (!unload_active_i) begin
            unl_cnt_d = 10'h0;
        end else if (tick_w && !below_w && !side_b_breaker_open_i && unl_cnt_q != SEC_MAX) begin
            unl_cnt_d = unl_cnt_q + 10'h1;
        end
        // open is commanded while unloading with the breaker not open, when power is below trip or the unload delay has expired
        open_d = unload_active_i && !side_b_breaker_open_i && (below_w || unl_exp_w);
        alarm_prev_d = alarm_w;
        open_prev_d = open_q;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pre_q <= 32'h0;
            sync_cnt_q <= 10'h0;
            unl_cnt_q <= 10'h0;
            open_q <= 1'b0;
            alarm_prev_q <= 2'h0;
            open_prev_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            sync_cnt_q <= sync_cnt_d;
            unl_cnt_q <= unl_cnt_d;
            open_q <= open_d;
            alarm_prev_q <= alarm_prev_d;
            open_prev_q <= open_prev_d;
        end
    end

    assign fault_w = {unl_exp_w, sync_fault_w};
    assign lockable_w = {ctrl_q[CTRL_UNL_LOCK], ctrl_q[CTRL_SYNC_LOCK]};
    assign self_ack_w = {ctrl_q[CTRL_UNL_SACK], ctrl_q[CTRL_SYNC_SACK]};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_alarm
            bsum_alarm u_alarm (
                .clk_i(clk_i),
                .reset_i(reset_i),
                .fault_i(fault_w[i]),
                .lockable_i(lockable_w[i]),
                .lock_i(monitor_lock_i),
                .self_ack_i(self_ack_w[i]),
                .ack_i(ack_w),
                .alarm_o(alarm_w[i])
            );
        end
    endgenerate

    assign sync_timeout_flag_o = alarm_w[0];
    assign sync_timeout_message_o = alarm_w[0];
    assign unload_mismatch_alarm_o = alarm_w[1];
    assign side_b_breaker_open_cmd_o = open_q;
    assign sync_class_o = bsum_class_e'(ctrl_q[CTRL_SYNC_CLS +: 3]);
    assign unload_class_o = bsum_class_e'(ctrl_q[CTRL_UNL_CLS +: 3]);
    assign irq_o = |(irq_stat_q & irq_mask_q);

    a_sync_mon_off: assert property (sync_fault_w |-> ctrl_q[CTRL_SYNC_EN])
        else $error("sync fault while monitoring off");
    a_sync_delay_met: assert property ($rose(alarm_w[0]) |-> $past(sync_cnt_q) >= $past(sync_dly_q))
        else $error("sync alarm before delay");
    a_sync_irq_post: assert property ($rose(sync_timeout_flag_o) |=> irq_stat_q[0])
        else $error("timeout not posted");
    a_class_legal: assert property (sync_class_o <= BSUM_CLS_CTRL && unload_class_o <= BSUM_CLS_CTRL)
        else $error("illegal alarm class");
    a_trip_opens: assert property (unload_active_i && below_w && !side_b_breaker_open_i
        |=> side_b_breaker_open_cmd_o)
        else $error("no open below trip level");
    a_unl_forced: assert property (unl_exp_w |=> side_b_breaker_open_cmd_o)
        else $error("no forced open after unload delay");
    a_mismatch_open: assert property ($rose(unload_mismatch_alarm_o) |-> side_b_breaker_open_cmd_o)
        else $error("mismatch alarm without open");
    a_sync_tmr_clr: assert property (!sync_active_i |=> sync_cnt_q == 10'h0)
        else $error("sync timer not cleared");
    a_unl_tmr_stop: assert property (unload_active_i && below_w |=> $stable(unl_cnt_q))
        else $error("unload timer ran below trip");
endmodule

// ### inc/bsum_pkg.sv
package bsum_pkg;
    // alarm classes, control class selects no shutdown action
    typedef enum logic [2:0] {
        BSUM_CLS_A,
        BSUM_CLS_B,
        BSUM_CLS_C,
        BSUM_CLS_D,
        BSUM_CLS_E,
        BSUM_CLS_F,
        BSUM_CLS_CTRL
    } bsum_class_e;

    // time base
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_PERIOD_S = 1;
    localparam int unsigned SEC_CYCLES = CLK_HZ * TICK_PERIOD_S;
    localparam logic [9:0] SEC_MAX = 10'h3FF;

    // apb register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SYNC_DLY = 8'h04;
    localparam logic [7:0] OFS_UNL_DLY = 8'h08;
    localparam logic [7:0] OFS_TRIP = 8'h0C;
    localparam logic [7:0] OFS_RATED = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
    localparam logic [7:0] OFS_ACK = 8'h20;

    // control field positions
    localparam int unsigned CTRL_SYNC_EN = 0;
    localparam int unsigned CTRL_SYNC_SACK = 1;
    localparam int unsigned CTRL_SYNC_LOCK = 2;
    localparam int unsigned CTRL_SYNC_CLS = 4;
    localparam int unsigned CTRL_UNL_SACK = 8;
    localparam int unsigned CTRL_UNL_LOCK = 9;
    localparam int unsigned CTRL_UNL_CLS = 12;

    // limits and reset values, delays in seconds, trip in 0.1 %
    localparam logic [9:0] SYNC_DLY_MIN = 10'd3;
    localparam logic [9:0] SYNC_DLY_MAX = 10'd999;
    localparam logic [9:0] SYNC_DLY_RST = 10'd60;
    localparam logic [9:0] UNL_DLY_MIN = 10'd1;
    localparam logic [9:0] UNL_DLY_MAX = 10'd999;
    localparam logic [9:0] UNL_DLY_RST = 10'd30;
    localparam logic [9:0] TRIP_MIN = 10'd5;
    localparam logic [9:0] TRIP_MAX = 10'd999;
    localparam logic [9:0] TRIP_RST = 10'd30;
    localparam logic [15:0] RATED_RST = 16'd1000;
    localparam logic [26:0] TRIP_SCALE = 27'd1000;
    localparam bsum_class_e CLS_RST = BSUM_CLS_B;
endpackage

// ### verif/bsum_breaker_model.sv
`timescale 1ns/1ps
// breaker b with its power feed; reset leaves it open
module bsum_breaker_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic open_cmd_i,
    input wire logic close_req_i,
    input wire logic [3:0] open_delay_i,
    input wire logic [15:0] load_i,
    output logic closed_o,
    output logic open_o,
    output logic [15:0] power_o
);
    logic open_q, open_d;
    logic [3:0] cnt_q, cnt_d;
    always_comb begin
        open_d = open_q;
        cnt_d = 4'h0;
        if (close_req_i && !open_cmd_i) begin
            open_d = 1'b0;
        end else if (open_cmd_i && !open_q) begin
            // slow mechanism: command must stand for the travel time
            cnt_d = cnt_q + 4'h1;
            if (cnt_q >= open_delay_i) begin
                open_d = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            open_q <= 1'b1;
            cnt_q <= 4'h0;
        end else begin
            open_q <= open_d;
            cnt_q <= cnt_d;
        end
    end
    assign open_o = open_q;
    assign closed_o = !open_q;
    // an open breaker carries no power
    assign power_o = open_q ? 16'h0000 : load_i;
endmodule

// ### verif/tb_breaker_sync_unload_monitor.sv
`timescale 1ns/1ps
module tb_breaker_sync_unload_monitor;
    import bsum_pkg::*;
    logic clk_i, reset_i, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic sync_act, closed, opened, unl_act, lock, pack, eack, open_cmd, flag, msg;
    logic unl_alarm, irq, close_req;
    logic [3:0] odly;
    logic [15:0] load, power;
    bsum_class_e scls, ucls;
    int mismatches, n_checks;
    logic [7:0] ra [7] = '{OFS_CTRL, OFS_SYNC_DLY, OFS_UNL_DLY, OFS_TRIP, OFS_RATED,
        OFS_IRQ_STAT, OFS_IRQ_MASK};
    logic [31:0] rv [7] = '{32'h1011, 32'h3C, 32'h1E, 32'h1E, 32'h3E8, 32'h0, 32'h0};
    logic [31:0] ur [4] = '{32'h3E8, 32'h3E8, 32'h7D0, 32'h7D0};
    logic [15:0] up [4] = '{16'd30, 16'd29, 16'd60, 16'd59};
    logic ue [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

    bsum_monitor #(.TICK_CYCLES(10)) bsum_monitor_i (.clk_i(clk_i), .reset_i(reset_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .sync_active_i(sync_act), .side_b_breaker_closed_i(closed),
        .side_b_breaker_open_i(opened), .unload_active_i(unl_act), .side_b_power_i(power),
        .monitor_lock_i(lock), .panel_ack_i(pack), .ext_ack_i(eack),
        .side_b_breaker_open_cmd_o(open_cmd), .sync_timeout_flag_o(flag),
        .sync_timeout_message_o(msg), .sync_class_o(scls),
        .unload_mismatch_alarm_o(unl_alarm), .unload_class_o(ucls), .irq_o(irq));
    bsum_breaker_model bsum_breaker_model_i (.clk_i(clk_i), .reset_i(reset_i),
        .open_cmd_i(open_cmd), .close_req_i(close_req), .open_delay_i(odly),
        .load_i(load), .closed_o(closed), .open_o(opened), .power_o(power));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1) begin
            mismatches++;
            test_done();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask

    function automatic logic mon(input int k);
        case (k)
            0: return flag;
            1: return open_cmd;
            2: return unl_alarm;
            default: return irq;
        endcase
    endfunction

    // waits at most lim cycles for the watched output to go high
    task automatic expect_hi(input string nm, input int k, input int lim, input logic exp);
        int c;
        c = 0;
        while (mon(k) !== 1'b1 && c < lim) begin
            @(posedge clk_i);
            c++;
        end
        chk(nm, 32'(mon(k) === 1'b1), 32'(exp));
        if (exp && c >= lim) test_done();
    endtask

    task automatic pulse(input int k);
        if (k == 0) pack <= 1'b1;
        else if (k == 1) eack <= 1'b1;
        else close_req <= 1'b1;
        @(posedge clk_i);
        pack <= 1'b0;
        eack <= 1'b0;
        close_req <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        mismatches++;
        test_done();
    end

    initial begin
        {reset_i, psel, penable, pwrite, paddr, pwdata} <= {1'b1, 43'h0};
        {sync_act, unl_act, lock, pack, eack, close_req} <= 6'h0;
        odly <= 4'h2;
        load <= 16'd500;
        repeat (16) @(posedge clk_i);
        reset_i <= 1'b0;
        chk("sync class", 32'(scls), 32'(BSUM_CLS_B));
        chk("unload class", 32'(ucls), 32'(BSUM_CLS_B));
        for (int i = 0; i < 7; i++) rchk(ra[i], rv[i], "reset value");
        apb(1'b0, 8'h24, 32'h0);
        chk("unmapped err", 32'(err), 32'h1);
        apb(1'b1, OFS_SYNC_DLY, 32'h1);
        rchk(OFS_SYNC_DLY, 32'h3, "sync delay");
        apb(1'b1, OFS_IRQ_MASK, 32'h7);
        // not lockable: the lock input must not hold the alarm back
        sync_act <= 1'b1;
        lock <= 1'b1;
        expect_hi("early sync alarm", 0, 18, 1'b0);
        expect_hi("sync alarm", 0, 20, 1'b1);
        chk("sync message", 32'(msg), 32'h1);
        expect_hi("irq", 3, 3, 1'b1);
        rchk(OFS_IRQ_STAT, 32'h1, "irq status");
        sync_act <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("latched alarm", 32'(flag), 32'h1);
        pulse(0);
        chk("panel ack", 32'(flag), 32'h0);
        apb(1'b1, OFS_IRQ_STAT, 32'h1);
        @(posedge clk_i);
        chk("irq cleared", 32'(irq), 32'h0);
        apb(1'b1, OFS_CTRL, 32'h1015);
        sync_act <= 1'b1;
        expect_hi("locked alarm", 0, 45, 1'b0);
        lock <= 1'b0;
        expect_hi("unlocked alarm", 0, 6, 1'b1);
        sync_act <= 1'b0;
        pulse(1);
        chk("external ack", 32'(flag), 32'h0);
        apb(1'b1, OFS_CTRL, 32'h1013);
        sync_act <= 1'b1;
        expect_hi("self ack alarm", 0, 45, 1'b1);
        sync_act <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("self cleared", 32'(flag), 32'h0);
        apb(1'b1, OFS_CTRL, 32'h1010);
        sync_act <= 1'b1;
        expect_hi("disabled alarm", 0, 45, 1'b0);
        sync_act <= 1'b0;
        apb(1'b1, OFS_CTRL, 32'h1011);
        sync_act <= 1'b1;
        repeat (12) @(posedge clk_i);
        pulse(2);
        expect_hi("closed alarm", 0, 40, 1'b0);
        sync_act <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, OFS_CTRL, 32'h1 | (i << 4) | (i << 12));
            @(posedge clk_i);
            chk("sync class", 32'(scls), (i == 7) ? 32'h1 : i);
            chk("unload class", 32'(ucls), (i == 7) ? 32'h1 : i);
        end
        apb(1'b1, OFS_CTRL, 32'h1011);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, OFS_RATED, ur[i]);
            load <= up[i];
            unl_act <= 1'b1;
            expect_hi("trip open", 1, 6, ue[i]);
            repeat (8) @(posedge clk_i);
            chk("open released", 32'(open_cmd), 32'h0);
            chk("no mismatch", 32'(unl_alarm), 32'h0);
            unl_act <= 1'b0;
            pulse(2);
        end
        apb(1'b1, OFS_RATED, 32'h3E8);
        apb(1'b1, OFS_UNL_DLY, 32'h0);
        rchk(OFS_UNL_DLY, 32'h1, "unload delay");
        apb(1'b1, OFS_IRQ_STAT, 32'h7);
        load <= 16'd500;
        odly <= 4'hF;
        unl_act <= 1'b1;
        expect_hi("mismatch", 2, 30, 1'b1);
        chk("forced open", 32'(open_cmd), 32'h1);
        rchk(OFS_STATUS, 32'h16, "status");
        repeat (20) @(posedge clk_i);
        unl_act <= 1'b0;
        // acknowledge through the register interface this time
        apb(1'b1, OFS_ACK, 32'h1);
        @(posedge clk_i);
        chk("mismatch ack", 32'(unl_alarm), 32'h0);
        rchk(OFS_IRQ_STAT, 32'h6, "irq status");
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        @(posedge clk_i);
        chk("irq masked", 32'(irq), 32'h0);
        // unload alarm with self acknowledge: clears once the slow breaker opens
        apb(1'b1, OFS_CTRL, 32'h1111);
        pulse(2);
        unl_act <= 1'b1;
        expect_hi("unload self ack", 2, 30, 1'b1);
        repeat (25) @(posedge clk_i);
        chk("unload self cleared", 32'(unl_alarm), 32'h0);
        unl_act <= 1'b0;
        test_done();
    end
endmodule
